/* src/sgc_map.svh */
/*
 constants for the serial gain control port: widths, sync depth, gain reset value and code limit.
 assumes inclusion by the package and the design modules by bare name.
*/
// Notes on behaviour
// RQ1: load window gates latch and shift register
// RQ2: window rising edge commits word to attenuator
// RQ3: window rising edge stops serial bit capture
// RQ4: window falling edge holds applied gain steady
// RQ5: window falling edge opens shift register loading
// RQ6: controller sends eight bits, msb first
// RQ7: rising clock captures master, falling moves slave
// RQ8: controller keeps data valid by capture edge
// RQ9: transmit_on low disables, high enables transmission
// RQ10: sleep_n low enters low power sleep
// RQ11: sleep_n high gives normal operation
// RQ12: seven stages kept, first bit drops out
// RQ13: controller sends codes 0 to 79 only
`ifndef SGC_MAP_SVH
`define SGC_MAP_SVH
`define SGC_WORD_BITS 8
`define SGC_STAGES 7
`define SGC_GAIN_RESET 7'h00
`define SGC_CODE_MAX 7'h4F
`define SGC_SYNC_DEPTH 3
`endif

/* src/sgc_pkg.sv */
/*
 types for the serial gain control port.
 assumes sgc_map.svh is on the include path.
*/
`include "sgc_map.svh"
package sgc_pkg;
   // power mode of the amplifier core
   typedef enum logic [1:0] {
      SGC_MODE_SLEEP = 2'b00,
      SGC_MODE_TX_OFF = 2'b01,
      SGC_MODE_TX_ON = 2'b10
   } sgc_mode_t;
   typedef logic [`SGC_STAGES-1:0] sgc_gain_t;
endpackage : sgc_pkg

/* src/sgc_pins_if.sv */
/*
 interface carrying synchronised pin levels and edges from the sampler.
 assumes one clock domain, clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface sgc_pins_if;
   logic sclk_rise; // serial clock rising edge pulse
   logic sclk_fall; // serial clock falling edge pulse
   logic win_rise; // load window rising edge pulse
   logic win_fall; // load window falling edge pulse
   logic win_n; // filtered load window level
   logic data; // filtered serial data level
   modport src (output sclk_rise, sclk_fall, win_rise, win_fall, win_n, data);
   modport dst (input sclk_rise, sclk_fall, win_rise, win_fall, win_n, data);
endinterface : sgc_pins_if
`default_nettype wire

/* src/sgc_sampler.sv */
/*
 three-stage samplers for the external pins and edge detection.
 assumes pins are asynchronous to clk; a change counts when stages 2 and 3 agree.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgc_map.svh"
module sgc_sampler (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic load_window_n,
   input wire logic serial_gain_in,
   sgc_pins_if.src pins
);
   // -----------------------------------------------------------
   // sampling chains, one per pin: clock, window, data
   // -----------------------------------------------------------
   logic [2:0] s1_r, s1_nxt; // first stage
   logic [2:0] s2_r, s2_nxt; // second stage
   logic [2:0] s3_r, s3_nxt; // third stage
   logic [2:0] lvl_r, lvl_nxt; // accepted level
   logic [2:0] rise, fall;

   // next values for the chains
   always_comb begin
      s1_nxt = {serial_gain_in, load_window_n, serial_clk};
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      lvl_nxt = lvl_r;
      for (int i = 0; i < 3; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            lvl_nxt[i] = s3_r[i];
         end
      end
   end

   // registers; window idles high, clock and data idle low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_r <= 3'h2;
         s2_r <= 3'h2;
         s3_r <= 3'h2;
         lvl_r <= 3'h2;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   // edges of the accepted level
   always_comb begin
      rise = lvl_nxt & ~lvl_r;
      fall = ~lvl_nxt & lvl_r;
   end

   assign pins.sclk_rise = rise[0];
   assign pins.sclk_fall = fall[0];
   assign pins.win_rise = rise[1];
   assign pins.win_fall = fall[1];
   assign pins.win_n = lvl_r[1];
   assign pins.data = lvl_nxt[2];
endmodule : sgc_sampler
`default_nettype wire

/* src/sgc_port.sv */
/*
 serial gain control port: shift register, holding latch, power mode.
 assumes the serial clock, load window, data and mode pins are asynchronous
 to clk and that the serial clock is at least 8 clk periods long.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgc_map.svh"
module sgc_port #(
   parameter int STAGES = `SGC_STAGES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic load_window_n,
   input wire logic serial_gain_in,
   input wire logic transmit_on,
   input wire logic sleep_n,
   output logic [STAGES-1:0] gain_code,
   output logic gain_update,
   output logic transmit_active,
   output logic sleep_active,
   output var sgc_pkg::sgc_mode_t power_mode,
   output logic loading
);
   // -----------------------------------------------------------
   // pin sampling
   // -----------------------------------------------------------
   sgc_pins_if pins ();

   sgc_sampler u_sampler (
      .clk(clk),
      .sys_rst(sys_rst),
      .serial_clk(serial_clk),
      .load_window_n(load_window_n),
      .serial_gain_in(serial_gain_in),
      .pins(pins)
   );

   // static mode pins pass their own three stages
   logic [1:0] m1_r, m1_nxt;
   logic [1:0] m2_r, m2_nxt;
   logic [1:0] m3_r, m3_nxt;
   logic [1:0] mode_lvl_r, mode_lvl_nxt; // {sleep_n, transmit_on}

   // -----------------------------------------------------------
   // serial datapath state
   // -----------------------------------------------------------
   logic open_r, open_nxt; // shift register accepting bits
   logic master_r, master_nxt; // master stage of the first cell
   logic [STAGES-1:0] slave_r, slave_nxt; // slave stages, lsb newest
   logic [STAGES-1:0] gain_r, gain_nxt; // holding latch to attenuator
   logic upd_r, upd_nxt; // one-cycle commit pulse
   logic tx_r, tx_nxt;
   logic slp_r, slp_nxt;
   sgc_pkg::sgc_mode_t mode_r, mode_nxt;

   // next values for the mode samplers
   always_comb begin
      m1_nxt = {sleep_n, transmit_on};
      m2_nxt = m1_r;
      m3_nxt = m2_r;
      mode_lvl_nxt = mode_lvl_r;
      for (int i = 0; i < 2; i++) begin
         if (m2_r[i] == m3_r[i]) begin
            mode_lvl_nxt[i] = m3_r[i];
         end
      end
   end

   // mode sampler registers; awake and transmit off at reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         m1_r <= 2'h2;
         m2_r <= 2'h2;
         m3_r <= 2'h2;
         mode_lvl_r <= 2'h2;
      end else begin
         m1_r <= m1_nxt;
         m2_r <= m2_nxt;
         m3_r <= m3_nxt;
         mode_lvl_r <= mode_lvl_nxt;
      end
   end

   // next values of the serial datapath
   always_comb begin
      open_nxt = open_r;
      master_nxt = master_r;
      slave_nxt = slave_r;
      gain_nxt = gain_r; // latch frozen unless committed RQ4
      upd_nxt = 1'b0;
      if (pins.win_fall) begin
         open_nxt = 1'b1; // RQ5
      end else if (pins.win_rise) begin
         open_nxt = 1'b0; // RQ3
         gain_nxt = slave_r; // RQ2
         upd_nxt = 1'b1; // RQ1
      end
      if (open_r && !pins.win_rise) begin
         if (pins.sclk_rise) begin
            master_nxt = pins.data; // RQ7
         end
         if (pins.sclk_fall) begin
            // oldest bit leaves the top; seven stages only RQ12
            slave_nxt = {slave_r[STAGES-2:0], master_r}; // RQ7
         end
      end
   end

   // next values of the power mode
   always_comb begin
      tx_nxt = mode_lvl_r[0]; // RQ9
      slp_nxt = ~mode_lvl_r[1]; // RQ10 RQ11
      if (!mode_lvl_r[1]) begin
         mode_nxt = sgc_pkg::SGC_MODE_SLEEP; // RQ10
      end else if (mode_lvl_r[0]) begin
         mode_nxt = sgc_pkg::SGC_MODE_TX_ON; // RQ9
      end else begin
         mode_nxt = sgc_pkg::SGC_MODE_TX_OFF; // RQ9
      end
   end

   // datapath and mode registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         open_r <= 1'b0;
         master_r <= 1'b0;
         slave_r <= '0;
         gain_r <= '0;
         upd_r <= 1'b0;
         tx_r <= 1'b0;
         slp_r <= 1'b0;
         mode_r <= sgc_pkg::SGC_MODE_TX_OFF;
      end else begin
         open_r <= open_nxt;
         master_r <= master_nxt;
         slave_r <= slave_nxt;
         gain_r <= gain_nxt;
         upd_r <= upd_nxt;
         tx_r <= tx_nxt;
         slp_r <= slp_nxt;
         mode_r <= mode_nxt;
      end
   end

   // -----------------------------------------------------------
   // outputs, all from flip-flops
   // -----------------------------------------------------------
   assign gain_code = gain_r;
   assign gain_update = upd_r;
   assign transmit_active = tx_r;
   assign sleep_active = slp_r;
   assign power_mode = mode_r;
   assign loading = open_r;
endmodule : sgc_port
`default_nettype wire

/* tb/sgc_port_monitor.sv */
/* checker for sgc_port: pin to output timing, commit pulse, power modes.
   assumes the 25 MHz clk and the design's own synchronous sys_rst. */
`timescale 1ns/1ps
`default_nettype none
// ----
// checker
// ----
module sgc_port_chk #(parameter int STAGES = 7) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic serial_clk,
   input wire logic load_window_n,
   input wire logic serial_gain_in,
   input wire logic transmit_on,
   input wire logic sleep_n,
   input wire logic [STAGES-1:0] gain_code,
   input wire logic gain_update,
   input wire logic transmit_active,
   input wire logic sleep_active,
   input wire logic [1:0] power_mode,
   input wire logic loading
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_pulse; gain_update |=> !gain_update; endproperty
   a_pulse: assert property (p_pulse) else $error("update too long");
   property p_hold; $changed(gain_code) |-> gain_update; endproperty
   a_hold: assert property (p_hold) else $error("gain moved");
   property p_open; $fell(load_window_n) |-> ##[2:6] loading; endproperty
   a_open: assert property (p_open) else $error("no open");
   property p_commit; $rose(load_window_n) && loading |-> ##[2:6] gain_update; endproperty
   a_commit: assert property (p_commit) else $error("no commit");
   property p_close; gain_update |-> !loading; endproperty
   a_close: assert property (p_close) else $error("still open");
   property p_idle; !loading |=> !gain_update; endproperty
   a_idle: assert property (p_idle) else $error("stray commit");
   // a window that has stood high for eight cycles leaves the register shut
   property p_shut; load_window_n [*8] |-> !loading; endproperty
   a_shut: assert property (p_shut) else $error("open while shut");
   property p_txon; $rose(transmit_on) |-> ##[3:7] transmit_active; endproperty
   a_txon: assert property (p_txon) else $error("tx not on");
   property p_txoff; $fell(transmit_on) |-> ##[3:7] !transmit_active; endproperty
   a_txoff: assert property (p_txoff) else $error("tx not off");
   property p_sleep; !sleep_n [*7] |-> sleep_active && power_mode == sgc_pkg::SGC_MODE_SLEEP;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no sleep");
   property p_wake; sleep_n [*7] |-> !sleep_active; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   // main scenarios reached
   cover property (gain_update);
   cover property (sleep_active);
   cover property (power_mode == sgc_pkg::SGC_MODE_TX_ON);
endmodule : sgc_port_chk
bind sgc_port sgc_port_chk #(.STAGES(STAGES)) u_chk (.clk(clk), .sys_rst(sys_rst),
   .serial_clk(serial_clk), .load_window_n(load_window_n), .serial_gain_in(serial_gain_in),
   .transmit_on(transmit_on), .sleep_n(sleep_n), .gain_code(gain_code),
   .gain_update(gain_update), .transmit_active(transmit_active),
   .sleep_active(sleep_active), .power_mode(power_mode), .loading(loading));
`default_nettype wire

/* tb/sgc_ctrl_model.sv */
/* controller model: frames gain words on the three serial pins.
   assumes clk of 40 ns; serial clock of 320 ns, low outside frames. */
`timescale 1ns/1ps
`default_nettype none
// ----
// controller
// ----
module sgc_ctrl_model (
   input wire logic clk,
   output logic serial_clk,
   output logic load_window_n,
   output logic serial_gain_in
);
   initial begin
      serial_clk = 1'b0;
      load_window_n = 1'b1;
      serial_gain_in = 1'b0;
   end
   // wait n falling clk edges
   task automatic gap(input int n);
      repeat (n) @(negedge clk);
   endtask : gap
   // one word, window opened only when open is set
   task automatic frame(input logic [7:0] w, input logic open);
      integer i;
      load_window_n = !open;
      gap(4);
      for (i = 7; i >= 0; i--) begin
         serial_gain_in = w[i];
         gap(4);
         serial_clk = 1'b1;
         gap(4);
         serial_clk = 1'b0;
      end
      gap(4);
      load_window_n = 1'b1;
      serial_gain_in = !w[0]; // released line shows the inverse
   endtask : frame
   // window opened and shut again with no serial clocks in between
   task automatic empty_window(input int n);
      load_window_n = 1'b0;
      gap(n);
      load_window_n = 1'b1;
   endtask : empty_window
endmodule : sgc_ctrl_model
`default_nettype wire

/* tb/sgc_port_tb_top.sv */
/* testbench for sgc_port: frames, stray clocks, power modes.
   assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fails++; \
   $display("mismatch %s exp %0h got %0h", n, e, a); end end
module sgc_port_tb_top;
   // ----
   // signals
   // ----
   logic clk, sys_rst, transmit_on, sleep_n, gain_update, transmit_active;
   logic sleep_active, loading, serial_clk, load_window_n, serial_gain_in;
   logic [6:0] gain_code;
   sgc_pkg::sgc_mode_t power_mode;
   int fails = 0, total_checks = 0, cyc = 0;
   sgc_ctrl_model u_ctl (.clk(clk), .serial_clk(serial_clk),
      .load_window_n(load_window_n), .serial_gain_in(serial_gain_in));
   sgc_port #(.STAGES(7)) DUT (.clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
      .load_window_n(load_window_n), .serial_gain_in(serial_gain_in),
      .transmit_on(transmit_on), .sleep_n(sleep_n), .gain_code(gain_code),
      .gain_update(gain_update), .transmit_active(transmit_active),
      .sleep_active(sleep_active), .power_mode(power_mode), .loading(loading));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // verdict and end of run
   task automatic end_sim;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         end_sim();
      end
   end
   // load a word, check hold in mid-frame and the commit
   task automatic t_load(input logic [7:0] w);
      logic [6:0] old;
      int i;
      old = gain_code;
      fork
         u_ctl.frame(w, 1'b1);
         begin
            u_ctl.gap(30);
            `CHK("loading", 1'b1, loading)
            `CHK("held", old, gain_code)
         end
      join
      for (i = 0; i < 8 && gain_update !== 1'b1; i++) @(negedge clk);
      `CHK("update", 1'b1, gain_update)
      `CHK("code", w[6:0], gain_code)
      `CHK("closed", 1'b0, loading)
   endtask : t_load
   // clocks with the window shut change nothing; an empty window then
   // commits the word still held from the last load, not the stray bits
   task automatic t_stray;
      logic [6:0] old;
      int i;
      old = gain_code;
      u_ctl.frame(8'h15, 1'b0);
      u_ctl.gap(8);
      `CHK("stray", old, gain_code)
      `CHK("shut", 1'b0, loading)
      u_ctl.empty_window(8);
      for (i = 0; i < 8 && gain_update !== 1'b1; i++) @(negedge clk);
      `CHK("empty update", 1'b1, gain_update)
      `CHK("stray kept out", old, gain_code)
   endtask : t_stray
   // reset in mid-run returns every output to its idle value
   task automatic t_reset;
      sys_rst = 1'b1;
      u_ctl.gap(3);
      sys_rst = 1'b0;
      `CHK("rst gain", 7'h00, gain_code)
      `CHK("rst update", 1'b0, gain_update)
      `CHK("rst loading", 1'b0, loading)
      `CHK("rst mode", sgc_pkg::SGC_MODE_TX_OFF, power_mode)
      `CHK("rst tx", 1'b0, transmit_active)
      `CHK("rst sleep", 1'b0, sleep_active)
      u_ctl.gap(8);
      `CHK("tx after rst", 1'b1, transmit_active)
   endtask : t_reset
   // all four static pin settings
   task automatic t_mode;
      int k;
      sgc_pkg::sgc_mode_t m;
      for (k = 0; k < 4; k++) begin
         sleep_n = k[1];
         transmit_on = k[0];
         u_ctl.gap(8);
         m = !k[1] ? sgc_pkg::SGC_MODE_SLEEP : k[0] ? sgc_pkg::SGC_MODE_TX_ON
            : sgc_pkg::SGC_MODE_TX_OFF;
         `CHK("mode", m, power_mode)
         `CHK("tx", k[0], transmit_active)
         `CHK("sleep", !k[1], sleep_active)
      end
   endtask : t_mode
   // main sequence
   initial begin
      sys_rst = 1'b1;
      transmit_on = 1'b0;
      sleep_n = 1'b1;
      u_ctl.gap(3);
      sys_rst = 1'b0;
      t_mode();
      t_load(8'h4F);
      t_load(8'hCA);
      t_stray();
      t_reset();
      t_load(8'h00);
      end_sim();
   end
endmodule : sgc_port_tb_top
`default_nettype wire
